// >>> scb_pkg.sv
// Package of constants, types and helpers for the serial config bank
package scb_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int       REG_COUNT = 13;
  localparam int       ADDR_W    = 5;
  localparam logic [4:0] OFS_GENERAL_CONTROL        = 5'h00;
  localparam logic [4:0] OFS_INTERFACE_CLOCK_SETUP  = 5'h01;
  localparam logic [4:0] OFS_CHAN_A_OFFSET_LOW      = 5'h0C;
  localparam logic [4:0] OFS_CHAN_A_GAIN            = 5'h0D;
  localparam logic [4:0] OFS_CHAN_B_OFFSET_HIGH     = 5'h0E;
  localparam logic [4:0] OFS_CHAN_B_OFFSET_LOW      = 5'h0F;
  localparam logic [4:0] OFS_CHAN_B_GAIN            = 5'h10;
  localparam logic [4:0] OFS_TRANSMIT_AMP_GAIN      = 5'h11;
  localparam logic [4:0] OFS_TRANSMIT_AMP_CONTROL   = 5'h12;
  localparam logic [4:0] OFS_DATA_FORMAT_AND_RATE   = 5'h13;
  localparam logic [4:0] OFS_PORT_MODE_SELECT       = 5'h14;
  localparam logic [4:0] OFS_CLOCK_MULTIPLIER_SETUP = 5'h15;
  localparam logic [4:0] OFS_CLOCK_ROUTING_SETUP    = 5'h16;
  // Bank index of the first register of the upper block
  localparam logic [3:0] IDX_UPPER_BASE = 4'h2;
  localparam logic [3:0] IDX_GENERAL    = 4'h0;
  localparam logic [3:0] IDX_CLOCK      = 4'h1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_GENERAL_CONTROL        = 8'h00;
  localparam logic [7:0] RST_INTERFACE_CLOCK_SETUP  = 8'h00;
  localparam logic [7:0] RST_CHAN_A_OFFSET_LOW      = 8'h00;
  localparam logic [7:0] RST_CHAN_A_GAIN            = 8'h00;
  localparam logic [7:0] RST_CHAN_B_OFFSET_HIGH     = 8'h00;
  localparam logic [7:0] RST_CHAN_B_OFFSET_LOW      = 8'h00;
  localparam logic [7:0] RST_CHAN_B_GAIN            = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_AMP_GAIN      = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_AMP_CONTROL   = 8'h00;
  localparam logic [7:0] RST_DATA_FORMAT_AND_RATE   = 8'h00;
  localparam logic [7:0] RST_PORT_MODE_SELECT       = 8'h00;
  localparam logic [7:0] RST_CLOCK_MULTIPLIER_SETUP = 8'h00;
  localparam logic [7:0] RST_CLOCK_ROUTING_SETUP    = 8'h00;

  typedef logic [REG_COUNT-1:0][7:0] scb_bank_t;

  localparam scb_bank_t RST_BANK = {
    RST_CLOCK_ROUTING_SETUP, RST_CLOCK_MULTIPLIER_SETUP,
    RST_PORT_MODE_SELECT, RST_DATA_FORMAT_AND_RATE,
    RST_TRANSMIT_AMP_CONTROL, RST_TRANSMIT_AMP_GAIN, RST_CHAN_B_GAIN,
    RST_CHAN_B_OFFSET_LOW, RST_CHAN_B_OFFSET_HIGH, RST_CHAN_A_GAIN,
    RST_CHAN_A_OFFSET_LOW, RST_INTERFACE_CLOCK_SETUP,
    RST_GENERAL_CONTROL};

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int         GEN_PIN_DIR_BIT    = 7;
  localparam int         GEN_LSB_FIRST_BIT  = 6;
  localparam int         GEN_SOFT_RESET_BIT = 5;
  localparam logic [7:0] GEN_STORE_MASK     = 8'hC0;
  localparam int         TSEL_MSB           = 7;
  localparam int         TSEL_LSB           = 5;
  localparam logic [2:0] TSEL_STANDARD      = 3'h0;
  localparam logic [2:0] TSEL_OPT_FULL      = 3'h1;
  localparam logic [2:0] TSEL_OPT_HALF_PAR  = 3'h3;
  localparam logic [2:0] TSEL_OPT_HALF_INTL = 3'h5;
  localparam logic [2:0] TSEL_CLONE         = 3'h7;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam logic [4:0] FRAME_BITS     = 5'h10;
  localparam logic [4:0] INSTR_BITS     = 5'h08;
  localparam int         INSTR_READ_BIT = 7;

  typedef enum logic [2:0] {
    TM_STANDARD,
    TM_OPT_FULL_DUPLEX,
    TM_OPT_HALF_PARALLEL,
    TM_OPT_HALF_INTERLEAVED,
    TM_CLONE,
    TM_UNUSED
  } scb_timing_t;

  function automatic logic [7:0] scb_reverse(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : scb_reverse

  // Returns {mapped, index}
  function automatic logic [4:0] scb_index(input logic [4:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a == OFS_GENERAL_CONTROL) begin
      r = {1'b1, IDX_GENERAL};
    end else if (a == OFS_INTERFACE_CLOCK_SETUP) begin
      r = {1'b1, IDX_CLOCK};
    end else if (a >= OFS_CHAN_A_OFFSET_LOW &&
                 a <= OFS_CLOCK_ROUTING_SETUP) begin
      r = {1'b1, 4'(a - OFS_CHAN_A_OFFSET_LOW) + IDX_UPPER_BASE};
    end
    return r;
  endfunction : scb_index

endpackage : scb_pkg

// >>> scb_ifs.sv
// Interfaces joining the frame engine, the bank and the crossing
`timescale 1ns/1ps

interface scb_frame_if;
  logic       lsbFirst;
  logic       threeWire;
  logic       wrEn;
  logic [4:0] wrAddr;
  logic [7:0] wrData;
  logic [4:0] rdAddr;
  logic [7:0] rdData;
  modport engine (input lsbFirst, threeWire, rdData,
                  output wrEn, wrAddr, wrData, rdAddr);
  modport bank   (output lsbFirst, threeWire, rdData,
                  input wrEn, wrAddr, wrData, rdAddr);
endinterface : scb_frame_if

interface scb_xfer_if;
  scb_pkg::scb_bank_t bank;
  logic               relock;
  logic               reqTgl;
  logic               ackTgl;
  modport src (output bank, relock, reqTgl, input ackTgl);
  modport dst (input bank, relock, reqTgl, output ackTgl);
endinterface : scb_xfer_if

// >>> scb_frame_shift.sv
// Serial frame engine on the port clock, cleared while select is high
`timescale 1ns/1ps

module scb_frame_shift
  import scb_pkg::*;
(
  input  wire logic  portClock,
  input  wire logic  frameRst,
  input  wire logic  sdioIn,
  output logic       sdioOut,
  output logic       sdioOe,
  output logic       serialDataOutPin,
  output logic       serialDataOutOe,
  scb_frame_if.engine frame
);

  typedef struct packed {
    logic [4:0] count;
    logic [7:0] shift;
    logic       isRead;
    logic [4:0] addr;
    logic [7:0] rdShift;
    logic       outBit;
    logic       sdioOe;
    logic       outPinOe;
  } scb_shift_state_t;

  scb_shift_state_t q;
  scb_shift_state_t d;
  logic [7:0]       rawByte;
  logic [7:0]       byteVal;
  logic [7:0]       rdOrder;

  assign sdioOut          = q.outBit;
  assign sdioOe           = q.sdioOe;
  assign serialDataOutPin = q.outBit;
  assign serialDataOutOe  = q.outPinOe;

  always_comb begin
    rawByte = {q.shift[6:0], sdioIn};
    byteVal = frame.lsbFirst ? scb_reverse(rawByte) : rawByte;
    rdOrder = frame.lsbFirst ? scb_reverse(frame.rdData)
                             : frame.rdData;
    frame.rdAddr = byteVal[4:0];
    frame.wrAddr = q.addr;
    frame.wrData = byteVal;
    frame.wrEn   = (q.count == FRAME_BITS - 5'h01) && !q.isRead;
    d = q;
    if (q.count != FRAME_BITS) begin
      d.count = q.count + 5'h01;
      d.shift = rawByte;
    end
    if (q.count == INSTR_BITS - 5'h01) begin
      d.isRead = byteVal[INSTR_READ_BIT];
      d.addr   = byteVal[4:0];
      if (byteVal[INSTR_READ_BIT]) begin
        d.outBit  = rdOrder[7];
        d.rdShift = {rdOrder[6:0], 1'b0};
        d.sdioOe  = frame.threeWire;
        d.outPinOe = !frame.threeWire;
      end
    end else if (q.isRead && q.count >= INSTR_BITS &&
                 q.count < FRAME_BITS - 5'h01) begin
      d.outBit  = q.rdShift[7];
      d.rdShift = {q.rdShift[6:0], 1'b0};
    end
  end

  // Select high clears the frame even with the port clock stopped
  always_ff @(posedge portClock or posedge frameRst) begin
    if (frameRst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : scb_frame_shift

// >>> scb_xfer_rx.sv
// System-side receiver of the bank snapshot handshake
`timescale 1ns/1ps

module scb_xfer_rx
  import scb_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  scb_xfer_if.dst   xfer,
  output logic      newValid
);

  typedef struct packed {
    logic reqSync1;
    logic reqSync2;
    logic reqSeen;
  } scb_rx_state_t;

  scb_rx_state_t q;
  scb_rx_state_t d;

  // Snapshot stays still until the acknowledge returns to its source
  assign xfer.ackTgl = q.reqSeen;
  assign newValid    = q.reqSync2 ^ q.reqSeen;

  always_comb begin
    d          = q;
    d.reqSync1 = xfer.reqTgl;
    d.reqSync2 = q.reqSync1;
    d.reqSeen  = q.reqSync2;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : scb_xfer_rx

// >>> scb_config_bank.sv
// Top of the serial configuration register bank
`timescale 1ns/1ps

module scb_config_bank
  import scb_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          portClock,
  input  wire logic          portSelN,
  input  wire logic          sdioIn,
  output logic               sdioOut,
  output logic               sdioOe,
  output logic               serialDataOutPin,
  output logic               serialDataOutOe,
  output scb_pkg::scb_bank_t configBank,
  output logic               pinDirectionSelect,
  output logic               lsbFirstMode,
  output scb_pkg::scb_timing_t timingMode,
  output logic               timingCodeUnused,
  output logic               cloneMode,
  output logic               pllRelock
);

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  scb_frame_if frame ();
  scb_xfer_if  xfer ();
  logic        frameRst;
  logic        newValid;

  // The frame's own select ends it; the port clock may stop at any time
  assign frameRst = sys_rst | portSelN;

  scb_frame_shift u_shift (
    .portClock        (portClock),
    .frameRst         (frameRst),
    .sdioIn           (sdioIn),
    .sdioOut          (sdioOut),
    .sdioOe           (sdioOe),
    .serialDataOutPin (serialDataOutPin),
    .serialDataOutOe  (serialDataOutOe),
    .frame            (frame.engine)
  );

  // ****************************************************************
  // Link-side bank and snapshot source
  // ****************************************************************
  typedef struct packed {
    scb_bank_t bank;
    scb_bank_t bundle;
    logic      relockBundle;
    logic      reqTgl;
    logic      ackSync1;
    logic      ackSync2;
    logic      pending;
    logic      relockPend;
  } scb_link_state_t;

  scb_link_state_t lq;
  scb_link_state_t ld;
  logic [4:0]      wrMap;
  logic [4:0]      rdMap;

  assign xfer.bank   = lq.bundle;
  assign xfer.relock = lq.relockBundle;
  assign xfer.reqTgl = lq.reqTgl;

  always_comb begin
    wrMap           = scb_index(frame.wrAddr);
    rdMap           = scb_index(frame.rdAddr);
    frame.lsbFirst  = lq.bank[IDX_GENERAL][GEN_LSB_FIRST_BIT];
    frame.threeWire = lq.bank[IDX_GENERAL][GEN_PIN_DIR_BIT];
    // Unmapped offsets read as zero
    frame.rdData    = rdMap[4] ? lq.bank[rdMap[3:0]] : 8'h00;
    ld              = lq;
    ld.ackSync1     = xfer.ackTgl;
    ld.ackSync2     = lq.ackSync1;
    // One snapshot in flight at a time; later writes are folded in
    if (lq.pending && lq.ackSync2 == lq.reqTgl) begin
      ld.bundle       = lq.bank;
      ld.relockBundle = lq.relockPend;
      ld.reqTgl       = !lq.reqTgl;
      ld.pending      = 1'b0;
      ld.relockPend   = 1'b0;
    end
    // A write in the send cycle wins over the clear of pending
    if (frame.wrEn && wrMap[4]) begin
      ld.pending = 1'b1;
      if (wrMap[3:0] == IDX_GENERAL) begin
        if (frame.wrData[GEN_SOFT_RESET_BIT]) begin
          ld.bank       = RST_BANK;
          ld.relockPend = 1'b1;
        end else begin
          ld.bank[IDX_GENERAL] = frame.wrData & GEN_STORE_MASK;
        end
      end else begin
        ld.bank[wrMap[3:0]] = frame.wrData;
      end
    end
  end

  always_ff @(posedge portClock or posedge sys_rst) begin
    if (sys_rst) begin
      lq        <= '0;
      lq.bank   <= RST_BANK;
      lq.bundle <= RST_BANK;
    end else begin
      lq <= ld;
    end
  end

  // ****************************************************************
  // System-side receiver
  // ****************************************************************
  scb_xfer_rx u_rx (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .xfer     (xfer.dst),
    .newValid (newValid)
  );

  function automatic scb_timing_t scb_decode(input logic [2:0] code);
    scb_timing_t t;
    unique case (code)
      TSEL_STANDARD:      t = TM_STANDARD;
      TSEL_OPT_FULL:      t = TM_OPT_FULL_DUPLEX;
      TSEL_OPT_HALF_PAR:  t = TM_OPT_HALF_PARALLEL;
      TSEL_OPT_HALF_INTL: t = TM_OPT_HALF_INTERLEAVED;
      TSEL_CLONE:         t = TM_CLONE;
      default:            t = TM_UNUSED;
    endcase
    return t;
  endfunction : scb_decode

  // ****************************************************************
  // System-side outputs
  // ****************************************************************
  typedef struct packed {
    scb_bank_t   cfg;
    scb_timing_t timing;
    logic        relock;
    logic        unused;
    logic        clone;
  } scb_sys_state_t;

  scb_sys_state_t sq;
  scb_sys_state_t sd;

  assign configBank         = sq.cfg;
  assign pinDirectionSelect = sq.cfg[IDX_GENERAL][GEN_PIN_DIR_BIT];
  assign lsbFirstMode       = sq.cfg[IDX_GENERAL][GEN_LSB_FIRST_BIT];
  assign timingMode         = sq.timing;
  assign timingCodeUnused   = sq.unused;
  assign cloneMode          = sq.clone;
  assign pllRelock          = sq.relock;

  always_comb begin
    sd        = sq;
    sd.relock = 1'b0;
    if (newValid) begin
      sd.cfg    = xfer.bank;
      sd.timing = scb_decode(xfer.bank[IDX_CLOCK][TSEL_MSB:TSEL_LSB]);
      // Flags registered so every output leaves a flip-flop
      sd.unused = (sd.timing == TM_UNUSED);
      sd.clone  = (sd.timing == TM_CLONE);
      sd.relock = xfer.relock;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sq        <= '0;
      sq.cfg    <= RST_BANK;
      sq.timing <= TM_STANDARD;
    end else begin
      sq <= sd;
    end
  end

endmodule : scb_config_bank

// >>> scb_config_bank_chk.sv
// Port assertions for the serial config bank
`timescale 1ns/1ps

module scb_config_bank_chk
  import scb_pkg::*;
(
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                portSelN,
  input wire logic                sdioOe,
  input wire logic                serialDataOutOe,
  input wire scb_pkg::scb_bank_t  configBank,
  input wire logic                pinDirectionSelect,
  input wire logic                lsbFirstMode,
  input wire scb_pkg::scb_timing_t timingMode,
  input wire logic                timingCodeUnused,
  input wire logic                cloneMode,
  input wire logic                pllRelock
);
  import scb_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [2:0] code;
  assign code = configBank[1][7:5];

  function automatic scb_timing_t tmap(input logic [2:0] c);
    case (c)
      TSEL_STANDARD:      return TM_STANDARD;
      TSEL_OPT_FULL:      return TM_OPT_FULL_DUPLEX;
      TSEL_OPT_HALF_PAR:  return TM_OPT_HALF_PARALLEL;
      TSEL_OPT_HALF_INTL: return TM_OPT_HALF_INTERLEAVED;
      TSEL_CLONE:         return TM_CLONE;
      default:            return TM_UNUSED;
    endcase
  endfunction : tmap

  // ****
  // Assertions
  // ****
  a_shared_pin_oe: assert property (sdioOe |-> pinDirectionSelect
    && !serialDataOutOe) else $error("shared pin driven in 4-wire mode");
  a_out_pin_oe: assert property (serialDataOutOe |->
    !pinDirectionSelect) else $error("out pin driven in 3-wire mode");
  // Two samples so a select edge on the clock edge cannot race
  a_oe_idle: assert property (portSelN [*2] |->
    !(sdioOe || serialDataOutOe)) else $error("pin driven between frames");
  a_relock_once: assert property (pllRelock |=> !pllRelock)
    else $error("relock pulse too long");
  a_relock_bank: assert property (pllRelock |-> configBank == RST_BANK)
    else $error("bank not at defaults with relock");
  a_soft_bit_clear: assert property (!configBank[0][5])
    else $error("soft reset bit stored");
  a_gen_spare_clear: assert property (configBank[0][4:0] == 5'h00)
    else $error("spare general bits stored");
  a_clone_flag: assert property ($stable(code) [*2] |->
    cloneMode == (code == TSEL_CLONE)) else $error("clone flag wrong");
  a_unused_flag: assert property ($stable(code) [*2] |->
    timingCodeUnused == (code inside {3'h2, 3'h4, 3'h6}))
    else $error("unused flag wrong");
  a_timing_map: assert property ($stable(code) [*2] |->
    timingMode == tmap(code)) else $error("timing mode wrong");
  cover property (sdioOe);
  cover property (serialDataOutOe);
  cover property (pllRelock);
  cover property (cloneMode);
endmodule : scb_config_bank_chk

bind scb_config_bank scb_config_bank_chk u_chk (
  .clock              (clock),
  .sys_rst            (sys_rst),
  .portSelN           (portSelN),
  .sdioOe             (sdioOe),
  .serialDataOutOe    (serialDataOutOe),
  .configBank         (configBank),
  .pinDirectionSelect (pinDirectionSelect),
  .lsbFirstMode       (lsbFirstMode),
  .timingMode         (timingMode),
  .timingCodeUnused   (timingCodeUnused),
  .cloneMode          (cloneMode),
  .pllRelock          (pllRelock)
);

// >>> scb_host_model.sv
// Host controller model driving the serial programming port
`timescale 1ns/1ps

module scb_host_model
  import scb_pkg::*;
(
  output logic      portClock,
  output logic      portSelN,
  output logic      sdioIn,
  input  wire logic sdioOut,
  input  wire logic sdioOe,
  input  wire logic serialDataOutPin,
  input  wire logic serialDataOutOe
);
  logic lsbF = 1'b0;
  logic threeW = 1'b0;
  logic drvBit = 1'b0;
  logic drvOn = 1'b1;
  // Released pin shows the inverse so a stale bit cannot pass as data
  assign sdioIn = sdioOe ? sdioOut : (drvOn ? drvBit : ~drvBit);
  initial begin
    portClock = 1'b0;
    portSelN = 1'b1;
  end

  task automatic xfer(input logic rd, input logic [4:0] adr,
                      input logic [7:0] wd, output logic [7:0] rdv);
    logic [15:0] fr;
    fr = {rd, 2'b00, adr, wd};
    rdv = 8'h00;
    portSelN = 1'b0;
    for (int k = 0; k < 16; k++) begin
      drvBit = fr[lsbF ? (k ^ 8) : 15 - k];
      drvOn = !(rd && threeW && k >= 8);
      #6;
      if (k >= 8) begin
        // Undriven out pin shows the inverse of its last bit
        rdv[lsbF ? k - 8 : 15 - k] = threeW ? sdioIn :
          (serialDataOutOe ? serialDataOutPin : ~serialDataOutPin);
      end
      portClock = 1'b1;
      #6;
      portClock = 1'b0;
    end
    #6;
    portSelN = 1'b1;
    drvOn = 1'b1;
    // Extra edges carry the snapshot across to the system clock
    repeat (4) begin
      #6 portClock = 1'b1;
      #6 portClock = 1'b0;
    end
    #60;
    if (!rd && adr == OFS_GENERAL_CONTROL) begin
      lsbF = wd[6] & ~wd[5];
      threeW = wd[7] & ~wd[5];
    end
  endtask : xfer
endmodule : scb_host_model

// >>> scb_config_bank_tb.sv
// Self-checking bench for the serial config bank
`timescale 1ns/1ps

module scb_config_bank_tb;
  import scb_pkg::*;
  logic        clock, sys_rst, portClock, portSelN, sdioIn, sdioOut;
  logic        sdioOe, serialDataOutPin, serialDataOutOe, cloneMode;
  logic        pinDirectionSelect, lsbFirstMode, timingCodeUnused;
  logic        pllRelock;
  scb_bank_t   configBank;
  scb_timing_t timingMode;
  int          err_count = 0;
  int          check_count = 0;
  int          relocks = 0;
  localparam scb_timing_t TMAP [8] = '{TM_STANDARD, TM_OPT_FULL_DUPLEX,
    TM_UNUSED, TM_OPT_HALF_PARALLEL, TM_UNUSED, TM_OPT_HALF_INTERLEAVED,
    TM_UNUSED, TM_CLONE};

  scb_config_bank u_dut (.clock(clock), .sys_rst(sys_rst),
    .portClock(portClock), .portSelN(portSelN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe),
    .serialDataOutPin(serialDataOutPin),
    .serialDataOutOe(serialDataOutOe), .configBank(configBank),
    .pinDirectionSelect(pinDirectionSelect), .lsbFirstMode(lsbFirstMode),
    .timingMode(timingMode), .timingCodeUnused(timingCodeUnused),
    .cloneMode(cloneMode), .pllRelock(pllRelock));
  scb_host_model u_host (.portClock(portClock), .portSelN(portSelN),
    .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .serialDataOutPin(serialDataOutPin), .serialDataOutOe(serialDataOutOe));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) if (pllRelock === 1'b1) relocks++;

  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(1'b0, a, d, x);
  endtask : wr
  task automatic rdc(input string what, input logic [4:0] a,
                     input logic [7:0] e);
    logic [7:0] x;
    u_host.xfer(1'b1, a, 8'h00, x);
    cmp(what, e, x);
  endtask : rdc
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 13; i++) begin
      rdc("default", i < 2 ? 5'(i) : 5'(i + 10), 8'h00);
    end
    rdc("unmapped", 5'h05, 8'h00);
    for (int i = 0; i < 11; i++) wr(5'(i + 12), 8'(8'h5A + 8'h13 * i));
    for (int i = 0; i < 11; i++) begin
      rdc("bank read", 5'(i + 12), 8'(8'h5A + 8'h13 * i));
      cmp("bank copy", 8'(8'h5A + 8'h13 * i), configBank[i + 2]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(OFS_INTERFACE_CLOCK_SETUP, {3'(c), 5'h13});
      rdc("clock setup", OFS_INTERFACE_CLOCK_SETUP, {3'(c), 5'h13});
      cmp("timing", 8'(TMAP[c]), 8'(timingMode));
      cmp("clone", {7'h00, c == 7}, {7'h00, cloneMode});
      cmp("unused", {7'h00, c inside {2, 4, 6}},
          {7'h00, timingCodeUnused});
    end
    wr(OFS_GENERAL_CONTROL, 8'h40);
    cmp("lsb first", 8'h01, {7'h00, lsbFirstMode});
    wr(OFS_CHAN_A_GAIN, 8'h1E);
    rdc("lsb read", OFS_CHAN_A_GAIN, 8'h1E);
    cmp("lsb copy", 8'h1E, configBank[3]);
    rdc("four wire", OFS_GENERAL_CONTROL, 8'h40);
    wr(OFS_GENERAL_CONTROL, 8'hDF);
    cmp("pin dir", 8'h01, {7'h00, pinDirectionSelect});
    rdc("three wire", OFS_GENERAL_CONTROL, 8'hC0);
    rdc("three wire gain", OFS_CHAN_A_GAIN, 8'h1E);
    relocks = 0;
    wr(OFS_GENERAL_CONTROL, 8'hE0);
    cmp("relock count", 8'h01, 8'(relocks));
    cmp("default gain", 8'h00, configBank[3]);
    rdc("after reset", OFS_GENERAL_CONTROL, 8'h00);
    rdc("after reset gain", OFS_CHAN_A_GAIN, 8'h00);
    close_out();
  end

  // Whole run needs about 19 us of frames
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule : scb_config_bank_tb
